// file: logic/wis_sequencer.sv
// weld initiation sequencer with its Avalon-MM register file
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wis_params.svh"

// Summary of operation
// - mode 02: pilot open in weld -> hold
// - mode 02: closed pilot runs full schedule
// - mode 02 includes squeeze-time pilot abort
// - mode 03: fast recovery, 30 to 60 ms
// - mode 03: check schedule only at initiation
// - modes 00-02, 04, 05: about 200 ms recovery
// - mode 03 initiates like non-beat mode
// - mode 04: inhibit input open ends weld
// - mode 05 unlocks cycle mode 05
// - mode 06: stop-pair closure resets stepper
// - firing delay enable, default on
// - firing delay only in manual power factor
// - power factor 00 automatic, else manual value
// - automatic readout shows last weld's factor
// - pre-squeeze only before first squeeze
// - pre-squeeze counted in line cycles
// - display dimmed during pre-squeeze
// - valve 3 on after blocking, until initiation
// - opening stop pair clears blocking output, except in mode 06
// - off shortened by blocking, or dropped
// - blocking overlap only cycle modes 00, 03
// - secondary = primary times turns ratio
// - mode 00: only stop halts a sequence
// - mode 01: pilot abort in pre-squeeze and squeeze only
module wis_sequencer import wis_pkg::*; #(
	parameter int unsigned FAST_REC_CYC = `WIS_FAST_REC_MS * `WIS_CLK_KHZ,
	parameter int unsigned STD_REC_CYC  = `WIS_STD_REC_MS * `WIS_CLK_KHZ
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        line_tick,
	input  wire logic        initiate,
	input  wire logic        estop_terminal,
	input  wire logic        weld_inhibit_input,
	input  wire logic [7:0]  pf_meas,
	input  wire logic [15:0] prim_current,
	output logic             valves_on,
	output logic             weld_fire,
	output logic             valve3,
	output logic             fire_delay_87,
	output logic             pf_manual,
	output logic             display_dim,
	output logic             ready,
	output logic             stepper_reset,
	output logic [23:0]      sec_current
);
	wis_st_t s_r;
	wis_st_t s_nxt;

	function automatic logic [31:0] rd_mux(input wis_st_t s,
		input logic [7:0] a);
		logic [7:0] pf;
		pf = (s.pf_set != 8'h00) ? s.pf_set : s.pf_last;
		if (a == `WIS_A_MODE) rd_mux = {24'h00_0000, s.mode};
		else if (a == `WIS_A_DCP) rd_mux = {31'h0000_0000, s.dcp};
		else if (a == `WIS_A_PF_SET) rd_mux = {24'h00_0000, s.pf_set};
		else if (a == `WIS_A_SQD) rd_mux = {24'h00_0000, s.sqd};
		else if (a == `WIS_A_SQZ) rd_mux = {24'h00_0000, s.sqz};
		else if (a == `WIS_A_WELD) rd_mux = {24'h00_0000, s.weld};
		else if (a == `WIS_A_HOLD) rd_mux = {24'h00_0000, s.hold};
		else if (a == `WIS_A_OFF) rd_mux = {24'h00_0000, s.off};
		else if (a == `WIS_A_BLK) rd_mux = {24'h00_0000, s.blk};
		else if (a == `WIS_A_CYC) rd_mux = {24'h00_0000, s.cyc};
		else if (a == `WIS_A_PO) rd_mux = {24'h00_0000, s.po};
		else if (a == `WIS_A_TR) rd_mux = {24'h00_0000, s.tr};
		else if (a == `WIS_A_CC) rd_mux = {24'h00_0000, s.cc};
		else if (a == `WIS_A_STATUS)
			rd_mux = {26'h000_0000, s.chk_ok, s.err, s.st == WIS_RECOVER,
				s.st};
		else if (a == `WIS_A_PF_READ) rd_mux = {24'h00_0000, pf};
		else if (a == `WIS_A_SEC) rd_mux = {8'h00, s.sec};
		else rd_mux = 32'h0000_0000;
	endfunction

	// a schedule with no weld time is treated as corrupt
	function automatic logic sched_ok(input wis_st_t s);
		sched_ok = (s.weld != 8'h00);
	endfunction

	logic stop_open;
	logic step_mode;
	logic pilot_abort;
	logic [31:0] rec_load;

	always_comb begin
		step_mode = (s_r.mode == `WIS_M_STEPPER);
		stop_open = ~estop_terminal & ~step_mode;
		// modes 00, 03, 05 never let the pilot abort
		pilot_abort = ~initiate & ((s_r.mode == `WIS_M_SQZ) |
			(s_r.mode == `WIS_M_SQZ_WELD));
		rec_load = (s_r.mode == `WIS_M_FAST) ? FAST_REC_CYC
			: STD_REC_CYC;
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.step = 1'b0;
		s_nxt.ack = 1'b0;
		s_nxt.es_q = estop_terminal;
		s_nxt.init_q = initiate;

		// bus: one wait state, data captured as waitrequest drops
		if ((read | write) & ~s_r.ack) begin
			s_nxt.ack = 1'b1;
			s_nxt.rdata = rd_mux(s_r, address);
		end
		if (s_r.ack & write) begin
			if (address == `WIS_A_MODE) s_nxt.mode = writedata[7:0];
			else if (address == `WIS_A_DCP) s_nxt.dcp = writedata[0];
			else if (address == `WIS_A_PF_SET)
				s_nxt.pf_set = writedata[7:0];
			else if (address == `WIS_A_SQD) s_nxt.sqd = writedata[7:0];
			else if (address == `WIS_A_SQZ) s_nxt.sqz = writedata[7:0];
			else if (address == `WIS_A_WELD) s_nxt.weld = writedata[7:0];
			else if (address == `WIS_A_HOLD) s_nxt.hold = writedata[7:0];
			else if (address == `WIS_A_OFF) s_nxt.off = writedata[7:0];
			else if (address == `WIS_A_BLK) s_nxt.blk = writedata[7:0];
			else if (address == `WIS_A_CYC) begin
				if (writedata[7:0] != `WIS_CYC_05 ||
					s_r.mode == `WIS_M_CYC5) begin
					s_nxt.cyc = writedata[7:0];
				end
			end
			else if (address == `WIS_A_PO) s_nxt.po = writedata[7:0];
			else if (address == `WIS_A_TR) s_nxt.tr = writedata[7:0];
			else if (address == `WIS_A_CC) s_nxt.cc = writedata[7:0];
		end

		// primary modes scale the measured current
		if (s_r.cc >= `WIS_CC_PRIM_LO && s_r.cc <= `WIS_CC_PRIM_HI)
			s_nxt.sec = 24'(prim_current) * 24'(s_r.tr);
		else
			s_nxt.sec = 24'h00_0000;

		if (step_mode & estop_terminal & ~s_r.es_q)
			s_nxt.step = 1'b1;

		// phase timers advance only on line cycles
		if (line_tick && s_r.cnt != 8'h00)
			s_nxt.cnt = s_r.cnt - 8'h01;

		case (s_r.st)
			WIS_RECOVER: begin
				if (s_r.rec == 32'h0000_0000) begin
					// fast mode skips the redundant check
					s_nxt.chk_ok = (s_r.mode == `WIS_M_FAST) |
						sched_ok(s_r);
					s_nxt.st = WIS_IDLE;
				end else begin
					s_nxt.rec = s_r.rec - 32'h0000_0001;
				end
			end
			WIS_IDLE: begin
				if (initiate & ~s_r.init_q) begin
					// checked at every initiation, even in fast mode
					if (sched_ok(s_r)) begin
						s_nxt.v3 = 1'b0;
						s_nxt.err = 1'b0;
						s_nxt.st = WIS_SQD;
						s_nxt.cnt = s_r.sqd;
					end else begin
						s_nxt.err = 1'b1;
					end
				end
			end
			WIS_SQD: begin
				if (pilot_abort) begin
					s_nxt.st = WIS_IDLE;
				end else if (s_r.cnt == 8'h00) begin
					s_nxt.st = WIS_SQZ;
					s_nxt.cnt = s_r.sqz;
				end
			end
			WIS_SQZ: begin
				if (pilot_abort) begin
					s_nxt.st = WIS_IDLE;
				end else if (s_r.cnt == 8'h00) begin
					s_nxt.st = WIS_WELD;
					s_nxt.cnt = s_r.weld;
				end
			end
			WIS_WELD: begin
				if ((s_r.cnt == 8'h00) ||
					(s_r.mode == `WIS_M_SQZ_WELD && !initiate) ||
					(s_r.mode == `WIS_M_INHIBIT &&
					!weld_inhibit_input)) begin
					s_nxt.st = WIS_HOLD;
					s_nxt.cnt = s_r.hold;
					if (s_r.pf_set == 8'h00)
						s_nxt.pf_last = pf_meas;
				end
			end
			WIS_HOLD: begin
				if (s_r.cnt == 8'h00) begin
					if ((s_r.cyc == `WIS_CYC_SINGLE ||
						s_r.cyc == `WIS_CYC_03) &&
						s_r.blk != 8'h00) begin
						s_nxt.st = WIS_BLK;
						s_nxt.cnt = s_r.blk;
					end else begin
						s_nxt.st = WIS_OFF;
						s_nxt.cnt = s_r.off;
					end
				end
			end
			WIS_BLK: begin
				if (s_r.cnt == 8'h00) begin
					if (s_r.po == `WIS_PO_BLOCK)
						s_nxt.v3 = 1'b1;
					// blocking overlaps off time
					if (s_r.off > s_r.blk) begin
						s_nxt.st = WIS_OFF;
						s_nxt.cnt = s_r.off - s_r.blk;
					end else begin
						s_nxt.st = WIS_IDLE;
					end
				end
			end
			WIS_OFF: begin
				if (s_r.cnt == 8'h00) begin
					// repeat skips the pre-squeeze
					if (s_r.cyc == `WIS_CYC_REPEAT && initiate) begin
						s_nxt.st = WIS_SQZ;
						s_nxt.cnt = s_r.sqz;
					end else begin
						s_nxt.st = WIS_IDLE;
					end
				end
			end
			default: s_nxt.st = WIS_RECOVER;
		endcase

		// stop pair open outside mode 06 aborts anything and holds recovery
		if (stop_open) begin
			s_nxt.st = WIS_RECOVER;
			s_nxt.rec = rec_load;
			s_nxt.v3 = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.st <= WIS_RECOVER;
			s_r.rec <= 32'h0000_0000;
			s_r.dcp <= `WIS_RST_DCP;
			s_r.pf_set <= `WIS_RST_PF;
			s_r.tr <= `WIS_RST_TR;
			// stop pair idles closed, so no false closure after reset
			s_r.es_q <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign waitrequest = (read | write) & ~s_r.ack;
	assign readdata = s_r.rdata;
	assign valves_on = (s_r.st == WIS_SQD) | (s_r.st == WIS_SQZ) |
		(s_r.st == WIS_WELD) | (s_r.st == WIS_HOLD);
	assign weld_fire = (s_r.st == WIS_WELD);
	assign valve3 = s_r.v3;
	assign pf_manual = (s_r.pf_set != 8'h00);
	assign fire_delay_87 = s_r.dcp & pf_manual;
	assign display_dim = (s_r.st == WIS_SQD);
	assign ready = (s_r.st != WIS_RECOVER);
	assign stepper_reset = s_r.step;
	assign sec_current = s_r.sec;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	weld_break_a: assert property (
		weld_fire && s_r.mode == `WIS_M_SQZ_WELD && !initiate &&
		estop_terminal |=> s_r.st == WIS_HOLD && !weld_fire)
		else $error("pilot open in weld did not go to hold");
	inhibit_hold_a: assert property (
		weld_fire && s_r.mode == `WIS_M_INHIBIT && !weld_inhibit_input
		&& estop_terminal |=> s_r.st == WIS_HOLD)
		else $error("inhibit input did not end weld");
	sqz_abort_a: assert property (
		s_r.st == WIS_SQZ && s_r.mode == `WIS_M_SQZ && !initiate &&
		estop_terminal |=> s_r.st == WIS_IDLE && !valves_on)
		else $error("squeeze not stopped on pilot open");
	nonbeat_keep_a: assert property (
		s_r.st == WIS_SQZ && s_r.mode == `WIS_M_NONBEAT &&
		estop_terminal |=> s_r.st != WIS_IDLE)
		else $error("non-beat sequence stopped without stop");
	stop_clear_a: assert property (
		!estop_terminal && s_r.mode != `WIS_M_STEPPER |=>
		!valve3 && !ready [*2])
		else $error("stop open did not clear blocking output");
	delay_gate_a: assert property (
		$rose(fire_delay_87) |-> pf_manual && s_r.dcp)
		else $error("firing delay active outside manual mode");
	dim_end_a: assert property (
		display_dim && s_r.cnt == 8'h00 && initiate && estop_terminal
		|=> !display_dim && s_r.st == WIS_SQZ)
		else $error("display still dim after pre-squeeze");
	repeat_skip_a: assert property (
		s_r.st == WIS_OFF && s_r.cnt == 8'h00 && initiate &&
		s_r.cyc == `WIS_CYC_REPEAT && estop_terminal
		|=> s_r.st == WIS_SQZ && !display_dim)
		else $error("repeat entered pre-squeeze again");
	sec_calc_a: assert property (
		s_r.cc == `WIS_CC_PRIM_LO |=>
		sec_current == $past(prim_current) * $past(s_r.tr))
		else $error("secondary current not primary times ratio");
	step_pulse_a: assert property (
		s_r.mode == `WIS_M_STEPPER && $rose(estop_terminal) |=>
		stepper_reset ##1 !stepper_reset)
		else $error("stepper reset not one pulse");
	blk_off_a: assert property (
		s_r.st == WIS_BLK && s_r.cnt == 8'h00 && s_r.off <= s_r.blk
		&& estop_terminal |=> s_r.st == WIS_IDLE)
		else $error("off period ran despite long blocking");
	// refusals and phase timing that the bench only sees indirectly
	bad_sched_a: assert property (
		s_r.st == WIS_IDLE && initiate && !s_r.init_q &&
		s_r.weld == 8'h00 && estop_terminal
		|=> s_r.st == WIS_IDLE && s_r.err)
		else $error("start with empty weld time not refused");
	start_clear_a: assert property (
		s_r.st == WIS_IDLE && initiate && !s_r.init_q &&
		s_r.weld != 8'h00 && estop_terminal
		|=> s_r.st == WIS_SQD && !valve3 && display_dim)
		else $error("start did not clear valve 3 or enter pre-squeeze");
	cyc5_lock_a: assert property (
		s_r.ack && write && address == `WIS_A_CYC &&
		writedata[7:0] == `WIS_CYC_05 && s_r.mode != `WIS_M_CYC5
		|=> $stable(s_r.cyc))
		else $error("cycle mode 05 taken while locked");
	tick_hold_a: assert property (
		s_r.st == WIS_SQD && s_r.cnt != 8'h00 && !line_tick &&
		!pilot_abort && estop_terminal
		|=> s_r.st == WIS_SQD && $stable(s_r.cnt))
		else $error("pre-squeeze counted without a line cycle");
	blk_skip_a: assert property (
		s_r.st == WIS_HOLD && s_r.cnt == 8'h00 && estop_terminal &&
		s_r.cyc != `WIS_CYC_SINGLE && s_r.cyc != `WIS_CYC_03
		|=> s_r.st == WIS_OFF)
		else $error("blocking ran outside cycle modes 00 and 03");
	weld_keep_a: assert property (
		weld_fire && s_r.cnt != 8'h00 && initiate &&
		weld_inhibit_input && estop_terminal
		|=> weld_fire)
		else $error("weld cut short with pilot closed");
	fast_load_a: assert property (
		!estop_terminal && s_r.mode == `WIS_M_FAST
		|=> s_r.rec == FAST_REC_CYC)
		else $error("fast recovery time not loaded");
	std_load_a: assert property (
		!estop_terminal && s_r.mode != `WIS_M_FAST &&
		s_r.mode != `WIS_M_STEPPER |=> s_r.rec == STD_REC_CYC)
		else $error("standard recovery time not loaded");

	weld_done_c: cover property (s_r.st == WIS_HOLD ##1 s_r.st == WIS_BLK);
	brk_c: cover property (weld_fire && !initiate
		&& s_r.mode == `WIS_M_SQZ_WELD);
	rec_c: cover property ($fell(ready) ##[1:200] ready);
	rpt_c: cover property (s_r.st == WIS_OFF ##1 s_r.st == WIS_SQZ);
	v3_c: cover property ($rose(valve3));
endmodule
`default_nettype wire

// file: shared/wis_params.svh
// offsets, reset values and timing figures of the weld initiation sequencer
`ifndef WIS_PARAMS_SVH
`define WIS_PARAMS_SVH

`define WIS_CLK_KHZ      200000
`define WIS_FAST_REC_MS  30
`define WIS_STD_REC_MS   200
`define WIS_LINE_HZ      60

`define WIS_A_MODE       8'h00
`define WIS_A_DCP        8'h04
`define WIS_A_PF_SET     8'h08
`define WIS_A_SQD        8'h0C
`define WIS_A_SQZ        8'h10
`define WIS_A_WELD       8'h14
`define WIS_A_HOLD       8'h18
`define WIS_A_OFF        8'h1C
`define WIS_A_BLK        8'h20
`define WIS_A_CYC        8'h24
`define WIS_A_PO         8'h28
`define WIS_A_TR         8'h2C
`define WIS_A_CC         8'h30
`define WIS_A_STATUS     8'h34
`define WIS_A_PF_READ    8'h38
`define WIS_A_SEC        8'h3C

`define WIS_M_NONBEAT    8'h00
`define WIS_M_SQZ        8'h01
`define WIS_M_SQZ_WELD   8'h02
`define WIS_M_FAST       8'h03
`define WIS_M_INHIBIT    8'h04
`define WIS_M_CYC5       8'h05
`define WIS_M_STEPPER    8'h06

`define WIS_CYC_SINGLE   8'h00
`define WIS_CYC_REPEAT   8'h01
`define WIS_CYC_03       8'h03
`define WIS_CYC_05       8'h05
`define WIS_PO_BLOCK     8'h01
`define WIS_CC_PRIM_LO   8'h10
`define WIS_CC_PRIM_HI   8'h19

`define WIS_RST_DCP      1'b1
`define WIS_RST_PF       8'h00
`define WIS_RST_TR       8'h0A

`endif

// file: shared/wis_pkg.sv
// types of the weld initiation sequencer
package wis_pkg;
	typedef enum logic [2:0] {
		WIS_RECOVER, WIS_IDLE, WIS_SQD, WIS_SQZ,
		WIS_WELD, WIS_HOLD, WIS_BLK, WIS_OFF
	} wis_state_t;

	typedef struct packed {
		wis_state_t  st;
		logic [31:0] rec;
		logic [7:0]  cnt;
		logic [7:0]  mode;
		logic        dcp;
		logic [7:0]  pf_set;
		logic [7:0]  sqd;
		logic [7:0]  sqz;
		logic [7:0]  weld;
		logic [7:0]  hold;
		logic [7:0]  off;
		logic [7:0]  blk;
		logic [7:0]  cyc;
		logic [7:0]  po;
		logic [7:0]  tr;
		logic [7:0]  cc;
		logic [7:0]  pf_last;
		logic [23:0] sec;
		logic        ack;
		logic [31:0] rdata;
		logic        v3;
		logic        step;
		logic        es_q;
		logic        init_q;
		logic        err;
		logic        chk_ok;
	} wis_st_t;
endpackage

// file: testbench/wis_far_side.sv
// far-side model: pilot switch, stop pair, inhibit input and mains ticks
`timescale 1ns/1ps
`default_nettype none
module wis_far_side #(
	parameter int TICK_DIV = 4
) (
	input  wire logic   clk,
	output logic        line_tick,
	output logic        initiate,
	output logic        estop_terminal,
	output logic        weld_inhibit_input,
	output logic [7:0]  pf_meas,
	output logic [15:0] prim_current
);
	int div = 0;
	initial begin
		line_tick = 1'b0;
		initiate = 1'b0;
		estop_terminal = 1'b1;
		weld_inhibit_input = 1'b1;
		pf_meas = 8'h4b;
		prim_current = 16'h0064;
	end
	// mains ticks run free, shortened so phases stay a few clocks long
	always @(posedge clk) begin
		div <= (div == TICK_DIV - 1) ? 0 : div + 1;
		line_tick <= (div == TICK_DIV - 1);
	end
	task automatic pilot(input logic v);
		@(posedge clk);
		initiate <= v;
	endtask
	// fresh meter readings, applied on a clock edge
	task automatic meas(input logic [7:0] pf, input logic [15:0] cur);
		@(posedge clk);
		pf_meas <= pf;
		prim_current <= cur;
	endtask
	task automatic inhibit(input logic v);
		@(posedge clk);
		weld_inhibit_input <= v;
	endtask
	// momentary opening of the stop pair, push-button style
	task automatic stop_pulse(input int n);
		@(posedge clk);
		estop_terminal <= 1'b0;
		repeat (n) @(posedge clk);
		estop_terminal <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: testbench/wis_sequencer_tb.sv
// register and sequence checks of the weld initiation sequencer
`timescale 1ns/1ps
`default_nettype none
`include "wis_params.svh"
module wis_sequencer_tb;
	logic        clk;
	logic        rstn;
	logic        read;
	logic        write;
	logic [7:0]  address;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic [31:0] q;
	logic        waitrequest;
	logic        line_tick;
	logic        initiate;
	logic        estop_terminal;
	logic        weld_inhibit_input;
	logic [7:0]  pf_meas;
	logic [15:0] prim_current;
	logic        valves_on;
	logic        weld_fire;
	logic        valve3;
	logic        fire_delay_87;
	logic        pf_manual;
	logic        display_dim;
	logic        ready;
	logic        stepper_reset;
	logic [23:0] sec_current;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n;
	logic [7:0]  sa [8] = '{`WIS_A_SQD, `WIS_A_SQZ, `WIS_A_WELD,
		`WIS_A_HOLD, `WIS_A_OFF, `WIS_A_BLK, `WIS_A_PO, `WIS_A_MODE};
	logic [7:0]  sv [8] = '{8'h03, 8'h03, 8'h04, 8'h03,
		8'h04, 8'h03, 8'h01, 8'h00};
	logic [7:0]  ccs [4] = '{8'h10, 8'h19, 8'h30, 8'h00};
	logic [7:0]  ms [3] = '{8'h01, 8'h02, 8'h04};

	wis_sequencer #(.FAST_REC_CYC(20), .STD_REC_CYC(100)) u_dut (
		.clk(clk), .rstn(rstn), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .line_tick(line_tick),
		.initiate(initiate), .estop_terminal(estop_terminal),
		.weld_inhibit_input(weld_inhibit_input), .pf_meas(pf_meas),
		.prim_current(prim_current), .valves_on(valves_on),
		.weld_fire(weld_fire), .valve3(valve3),
		.fire_delay_87(fire_delay_87), .pf_manual(pf_manual),
		.display_dim(display_dim), .ready(ready),
		.stepper_reset(stepper_reset), .sec_current(sec_current)
	);
	wis_far_side u_far (
		.clk(clk), .line_tick(line_tick), .initiate(initiate),
		.estop_terminal(estop_terminal),
		.weld_inhibit_input(weld_inhibit_input),
		.pf_meas(pf_meas), .prim_current(prim_current)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= ~w;
		write <= w;
		// no limit of its own: if waitrequest stays high, only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, q, e);
	endtask
	task automatic wait_st(input logic [2:0] s);
		int k;
		k = 0;
		do begin
			bus(1'b0, `WIS_A_STATUS, 32'h0000_0000);
			k++;
		end while (q[2:0] !== s && k < 200);
		chk("state", q[2:0], s);
	endtask
	task automatic recov(input int lo, input int hi);
		u_far.stop_pulse(3);
		n = 0;
		while (ready !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("rec_lo", n >= lo, 1);
		chk("rec_hi", n <= hi, 1);
	endtask

	initial begin
		rstn <= 1'b0;
		read <= 1'b0;
		write <= 1'b0;
		address <= 8'h00;
		writedata <= 32'h0000_0000;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(negedge clk);
		chk("ready", ready, 1);
		rc("dcp", `WIS_A_DCP, 1);
		rc("pf_set", `WIS_A_PF_SET, 0);
		rc("tr", `WIS_A_TR, 32'h0000_000a);
		rc("unmapped", 8'hfc, 0);
		chk("fd87", fire_delay_87, 0);
		wr(`WIS_A_PF_SET, 32'h0000_0055);
		rc("pf_read", `WIS_A_PF_READ, 32'h0000_0055);
		@(negedge clk);
		chk("pf_manual", pf_manual, 1);
		chk("fd87", fire_delay_87, 1);
		wr(`WIS_A_DCP, 0);
		repeat (2) @(negedge clk);
		chk("fd87", fire_delay_87, 0);
		wr(`WIS_A_PF_SET, 0);
		u_far.meas(8'h4b, 16'h00c8);
		foreach (ccs[i]) begin
			wr(`WIS_A_CC, ccs[i]);
			repeat (2) @(negedge clk);
			chk("sec", sec_current, ccs[i] inside {8'h10, 8'h19} ?
				24'h00_07d0 : 24'h00_0000);
		end
		wr(`WIS_A_CYC, 5);
		rc("cyc", `WIS_A_CYC, 0);
		wr(`WIS_A_MODE, 5);
		wr(`WIS_A_CYC, 5);
		rc("cyc", `WIS_A_CYC, 5);
		wr(`WIS_A_CYC, 0);
		foreach (sa[i]) wr(sa[i], sv[i]);
		u_far.pilot(1'b1);
		repeat (3) @(negedge clk);
		chk("dim", display_dim, 1);
		chk("valves", valves_on, 1);
		// momentary closure only: the schedule must still run out
		u_far.pilot(1'b0);
		wait_st(3);
		chk("dim", display_dim, 0);
		wait_st(5);
		wait_st(1);
		chk("valve3", valve3, 1);
		u_far.meas(8'h2d, 16'h00c8);
		rc("pf_read", `WIS_A_PF_READ, 32'h0000_004b);
		recov(95, 110);
		chk("valve3", valve3, 0);
		wr(`WIS_A_MODE, 3);
		recov(18, 25);
		// empty weld time: start refused, error flag raised
		wr(`WIS_A_WELD, 0);
		u_far.pilot(1'b1);
		repeat (3) @(negedge clk);
		rc("status", `WIS_A_STATUS, 32'h0000_0031);
		chk("valves", valves_on, 0);
		u_far.pilot(1'b0);
		wr(`WIS_A_WELD, 4);
		for (int m = 1; m <= 2; m++) begin
			wr(`WIS_A_MODE, m);
			u_far.pilot(1'b1);
			wait_st(3);
			u_far.pilot(1'b0);
			repeat (3) @(negedge clk);
			chk("valves", valves_on, 0);
			wait_st(1);
		end
		wr(`WIS_A_OFF, 2);
		foreach (ms[i]) begin
			wr(`WIS_A_MODE, ms[i]);
			u_far.pilot(1'b1);
			wait_st(4);
			if (ms[i] == 8'h04) u_far.inhibit(1'b0);
			else u_far.pilot(1'b0);
			repeat (3) @(negedge clk);
			chk("fire", weld_fire, ms[i] == 8'h01);
			chk("valves", valves_on, 1);
			u_far.pilot(1'b0);
			u_far.inhibit(1'b1);
			wait_st(1);
		end
		// repeat: no blocking, second squeeze without pre-squeeze
		wr(`WIS_A_CYC, 1);
		u_far.pilot(1'b1);
		wait_st(7);
		chk("valve3", valve3, 0);
		wait_st(3);
		chk("dim", display_dim, 0);
		u_far.pilot(1'b0);
		wait_st(1);
		rc("pf_read", `WIS_A_PF_READ, 32'h0000_002d);
		wr(`WIS_A_MODE, 6);
		u_far.stop_pulse(2);
		n = 0;
		repeat (5) begin
			@(negedge clk);
			n += stepper_reset;
		end
		chk("step", n, 1);
		chk("ready", ready, 1);
		end_sim();
	end
endmodule
`default_nettype wire
